// File: dv/tb_top.sv
`timescale 1ns/1ps
// Bench that drives the option block over APB and its line pins.
module tb_top import tloc_pkg::*;;
	logic clk_sys = 1'b0, rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, seen_err;
	logic err_ev = 1'b0, yel_req = 1'b0, tx_stb = 1'b0, tx_bit = 1'b0;
	logic line_cmd = 1'b0, pay_cmd = 1'b0, ask = 1'b0;
	logic lcode, pcode, hreq, tx_pos, tx_neg, lloop, ploop, refr;
	logic yel_tx, dte_drv, prm_send, hist_send, prev_pos;
	logic [7:0] idle_byte;
	logic [1:0] tsel;
	logic [3:0] prm_data;
	logic [6:0] hcount;
	int prm_cnt, hist_cnt, errors = 0, n_tests = 0, cyc = 0, pulses, base;
	int viol;

	// Design and network model.
	tloc_line_opts #(.SEC_CYCLES(20)) i_tloc_line_opts (
		.clk_sys_i(clk_sys), .rst_n_i(rst_n), .ce_i(1'b1),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.line_loopback_enable_code_i(lcode), .payload_loopback_enable_code_i(pcode),
		.hist_req_i(hreq), .err_event_i(err_ev), .yellow_req_i(yel_req),
		.tx_stb_i(tx_stb), .tx_bit_i(tx_bit), .tx_pos_o(tx_pos),
		.tx_neg_o(tx_neg), .line_loop_o(lloop), .payload_loop_o(ploop),
		.reframe_o(refr), .idle_byte_o(idle_byte), .yellow_tx_o(yel_tx),
		.timing_sel_o(tsel), .dte_clk_drive_o(dte_drv),
		.prm_send_o(prm_send), .prm_data_o(prm_data),
		.hist_send_o(hist_send), .hist_count_o(hcount)
	);
	tloc_net_model i_tloc_net_model (
		.clk_sys_i(clk_sys), .rst_n_i(rst_n), .line_cmd_i(line_cmd),
		.pay_cmd_i(pay_cmd), .ask_i(ask), .prm_send_i(prm_send),
		.hist_send_i(hist_send), .line_loopback_enable_code_o(lcode),
		.payload_loopback_enable_code_o(pcode), .hist_req_o(hreq),
		.prm_cnt_o(prm_cnt), .hist_cnt_o(hist_cnt)
	);

	// The system clock runs at 100 MHz.
	always #5 clk_sys = ~clk_sys;

	// A hang is cut short after a cycle ceiling.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		seen_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask

	// Presses keys given as nibbles, lowest first.
	task automatic walk(input logic [31:0] s, input int n);
		for (int i = 0; i < n; i++) begin
			apb(1'b1, OFF_KEYS, 32'h1 << s[4 * i +: 4]);
		end
	endtask

	// One line bit; pulses leaving from the ninth strobe on are counted.
	task automatic strobe(input logic b, input int i);
		tx_stb <= 1'b1;
		tx_bit <= b;
		@(posedge clk_sys);
		tx_stb <= 1'b0;
		@(posedge clk_sys);
		if (i >= 9 && (tx_pos === 1'b1 || tx_neg === 1'b1)) begin
			pulses++;
			// A pulse of the same polarity as the one before is a violation.
			if (tx_pos === prev_pos) begin
				viol++;
			end
			prev_pos = tx_pos;
		end
	endtask

	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk("opts", OFF_OPTS, 32'h7ff, 32'h001);
		rchk("intv", OFF_INTV, 32'h7f, 32'h01);
		apb(1'b1, OFF_OPTS, 32'hffffffff);
		rchk("opts ro", OFF_OPTS, 32'h7ff, 32'h001);
		rchk("unmapped", 8'h14, 32'hffffffff, 32'h0);
		chk("slverr", seen_err, 1'b1);
		line_cmd <= 1'b1;
		pay_cmd <= 1'b1;
		ask <= 1'b1;
		yel_req <= 1'b1;
		repeat (60) @(posedge clk_sys);
		chk("line loop off", lloop, 1'b0);
		chk("pay loop off", ploop, 1'b0);
		chk("hist off", hist_cnt, 0);
		chk("prm off", prm_cnt, 0);
		chk("yellow off", yel_tx, 1'b0);
		chk("idle ff", idle_byte, IDLE_ONES);
		chk("dte clk", dte_drv, 1'b1);
		ask <= 1'b0;
		walk(32'h04, 2);
		rchk("to line", OFF_VIEW, 32'hf, 32'h1);
		walk(32'h1, 1);
		rchk("to dte", OFF_VIEW, 32'hf, 32'h2);
		walk(32'h204, 3);
		rchk("to cfg", OFF_VIEW, 32'hf, 32'h0);
		walk(32'h004, 3);
		rchk("frame", OFF_VIEW, 32'h3f, 32'h13);
		walk(32'h0, 1);
		rchk("frame sf", OFF_VIEW, 32'h3f, 32'h03);
		walk(32'h2, 1);
		rchk("unsaved", OFF_OPTS, 32'h7ff, 32'h001);
		walk(32'h10, 2);
		walk(32'h10101010, 8);
		rchk("seq a", OFF_VIEW, 32'hf, 32'h8);
		rchk("opts a", OFF_OPTS, 32'h7ff, 32'h01f);
		walk(32'h100, 3);
		@(posedge clk_sys);
		chk("timing", tsel, TIME_DTE);
		chk("dte clk dte", dte_drv, 1'b0);
		walk(32'h10101010, 8);
		rchk("seq b", OFF_VIEW, 32'hf, 32'h1);
		rchk("opts b", OFF_OPTS, 32'h7ff, 32'h7df);
		ask <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk("line loop", lloop, 1'b1);
		chk("pay loop", ploop, 1'b1);
		chk("reframe", refr, 1'b1);
		chk("hist", hist_cnt, 1);
		chk("hist count", hcount, 7'h00);
		chk("idle 7f", idle_byte, IDLE_7F);
		chk("yellow", yel_tx, 1'b1);
		err_ev <= 1'b1;
		base = prm_cnt;
		repeat (120) @(posedge clk_sys);
		chk("prm count", prm_cnt - base, 6);
		chk("prm data", prm_data, 4'hf);
		pulses = 0;
		viol = 0;
		prev_pos = 1'b0;
		for (int i = 1; i <= 18; i++) begin
			strobe(i == 1 || i > 9, i);
		end
		chk("b8zs pulses", pulses, 6);
		chk("b8zs violations", viol, 2);
		apb(1'b1, OFF_INTV, 32'h60);
		apb(1'b1, OFF_INTV, 32'h0);
		apb(1'b1, OFF_INTV, 32'h61);
		rchk("intv max", OFF_INTV, 32'h7f, 32'h60);
		walk(32'h103, 3);
		rchk("topt", OFF_VIEW, 32'hcf, 32'h4e);
		walk(32'h01011, 5);
		rchk("next intv", OFF_VIEW, 32'h70f, 32'h10f);
		rchk("wrap", OFF_INTV, 32'h7f, 32'h01);
		walk(32'h11111, 5);
		rchk("six cats", OFF_VIEW, 32'h70f, 32'h00f);
		// Back to AMI with stuffing on: fifteen zeros out force a mark as the next symbol.
		walk(32'h2101004, 7);
		rchk("opts ami", OFF_OPTS, 32'h7ff, 32'h7dd);
		pulses = 0;
		for (int i = 1; i <= 24; i++) begin
			strobe(1'b0, i);
		end
		chk("stuff mark", pulses, 1);
		finish_test();
	end
endmodule

// File: dv/tloc_net_model.sv
`timescale 1ns/1ps
// Network side: loop codes, history requests and reply counters.
module tloc_net_model (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Commands from the bench.
	input wire logic line_cmd_i,
	input wire logic pay_cmd_i,
	input wire logic ask_i,
	// Device outputs watched.
	input wire logic prm_send_i,
	input wire logic hist_send_i,
	// Pins toward the device and counts.
	output logic line_loopback_enable_code_o,
	output logic payload_loopback_enable_code_o,
	output logic hist_req_o,
	output int prm_cnt_o,
	output int hist_cnt_o
);
	// Codes and requests are levels held while the bench asks for them.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_loopback_enable_code_o <= 1'b0;
			payload_loopback_enable_code_o <= 1'b0;
			hist_req_o <= 1'b0;
		end else begin
			line_loopback_enable_code_o <= line_cmd_i;
			payload_loopback_enable_code_o <= pay_cmd_i;
			hist_req_o <= ask_i;
		end
	end
	// Reports and history replies from the device are counted.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prm_cnt_o <= 0;
			hist_cnt_o <= 0;
		end else begin
			prm_cnt_o <= prm_cnt_o + int'(prm_send_i);
			hist_cnt_o <= hist_cnt_o + int'(hist_send_i);
		end
	end
endmodule

// File: include/tloc_pkg.sv
package tloc_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFF_OPTS = 8'h00;
	localparam logic [7:0] OFF_KEYS = 8'h04;
	localparam logic [7:0] OFF_VIEW = 8'h08;
	localparam logic [7:0] OFF_INTV = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	// Key register bit positions.
	localparam int KEY_YES = 0;
	localparam int KEY_NO = 1;
	localparam int KEY_HOME = 2;
	localparam int KEY_PERF = 3;
	localparam int KEY_CFG = 4;
	// Interval and category limits.
	localparam logic [6:0] INTV_FIRST = 7'h01;
	localparam logic [6:0] INTV_LAST = 7'h60;
	localparam logic [2:0] CAT_LAST = 3'h5;
	localparam logic [1:0] TOPT_LAST = 2'h2;
	localparam logic [1:0] TIME_DTE = 2'h2;
	localparam logic [1:0] TIME_LAST = 2'h2;
	// Second timing and history sizes.
	localparam int CLK_HZ = 100000000;
	localparam int SEC_PER_INTV = 900;
	localparam int PRM_SECS = 4;
	localparam int ZERO_RUN = 8;
	localparam logic [3:0] STUFF_ZEROS = 4'hf;
	// Idle patterns.
	localparam logic [7:0] IDLE_ONES = 8'hff;
	localparam logic [7:0] IDLE_7F = 8'h7f;
	// Line symbol codes and the zero-run substitution, oldest first.
	localparam logic [1:0] SYM_Z = 2'h0;
	localparam logic [1:0] SYM_M = 2'h1;
	localparam logic [1:0] SYM_V = 2'h2;
	localparam logic [15:0] SUB_PAT = 16'h0249;
	// Saved option layout in the options register.
	localparam int O_ESF = 0;
	localparam int O_B8ZS = 1;
	localparam int O_STUFF = 2;
	localparam int O_PRM = 3;
	localparam int O_HIST = 4;
	localparam int O_TIM = 5;
	localparam int O_LLB = 7;
	localparam int O_PLB = 8;
	localparam int O_IDLE = 9;
	localparam int O_YEL = 10;
	localparam int O_W = 11;
	localparam logic [10:0] OPTS_RST = 11'h001;
	typedef enum logic [3:0] {
		MS_CFG, MS_LINE, MS_DTE, MS_FRAME, MS_CODE, MS_STUFF, MS_PRM,
		MS_HIST, MS_TIMING, MS_LLB, MS_PLB, MS_IDLE, MS_YEL,
		MS_PERF, MS_TPROMPT, MS_TVIEW
	} tloc_menu_type;
endpackage

// File: rtl/tloc_line_opts.sv
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module tloc_line_opts import tloc_pkg::*; #(
	parameter int SEC_CYCLES = CLK_HZ
) (
	// Clock, reset and enable.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Line pins and events.
	input wire logic line_loopback_enable_code_i,
	input wire logic payload_loopback_enable_code_i,
	input wire logic hist_req_i,
	input wire logic err_event_i,
	input wire logic yellow_req_i,
	input wire logic tx_stb_i,
	input wire logic tx_bit_i,
	// Line controls out.
	output logic tx_pos_o,
	output logic tx_neg_o,
	output logic line_loop_o,
	output logic payload_loop_o,
	output logic reframe_o,
	output logic [7:0] idle_byte_o,
	output logic yellow_tx_o,
	output logic [1:0] timing_sel_o,
	output logic dte_clk_drive_o,
	output logic prm_send_o,
	output logic [3:0] prm_data_o,
	output logic hist_send_o,
	output logic [6:0] hist_count_o
);
	tloc_menu_type state;
	logic [O_W-1:0] opts;
	logic [1:0] shown;
	logic [1:0] topt;
	logic [6:0] intv;
	logic [2:0] cat;
	logic [2:0] llb_s, plb_s, hreq_s;
	logic [31:0] sec_cnt;
	logic [9:0] intv_sec;
	logic sec_tick;
	logic [15:0] sym;
	logic last_pos;
	logic [3:0] zrun;
	logic wr, rd, mapped;
	logic k_yes, k_no, k_home;
	logic [1:0] out_sym;

	// APB decode; the slave always answers in the access cycle.
	assign wr = psel_i & penable_i & pwrite_i & ce_i;
	assign rd = psel_i & ~pwrite_i;
	assign mapped = paddr_i == OFF_OPTS || paddr_i == OFF_KEYS ||
		paddr_i == OFF_VIEW || paddr_i == OFF_INTV || paddr_i == OFF_STAT;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign k_yes = wr && paddr_i == OFF_KEYS && pwdata_i[KEY_YES];
	assign k_no = wr && paddr_i == OFF_KEYS && pwdata_i[KEY_NO];
	assign k_home = wr && paddr_i == OFF_KEYS && pwdata_i[KEY_HOME];

	// Read data register.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0;
		end else if (ce_i && rd && !penable_i) begin
			case (paddr_i)
				OFF_OPTS: prdata_o <= {21'h0, opts};
				OFF_VIEW: prdata_o <= {21'h0, cat, topt, shown, 4'(state)};
				OFF_INTV: prdata_o <= {25'h0, intv};
				OFF_STAT: prdata_o <= {23'h0, hist_count_o, payload_loop_o,
					line_loop_o};
				default: prdata_o <= 32'h0;
			endcase
		end
	end

	// Menu walk over the keys; options change only on a save.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= MS_CFG;
			opts <= OPTS_RST;
			shown <= 2'h0;
			topt <= 2'h0;
			cat <= 3'h0;
		end else if (wr && paddr_i == OFF_KEYS && pwdata_i[KEY_PERF]) begin
			state <= MS_PERF;
		end else if (wr && paddr_i == OFF_KEYS && pwdata_i[KEY_CFG]) begin
			state <= MS_CFG;
		end else if (k_yes || k_no || k_home) begin
			case (state)
				MS_CFG: begin
					if (k_yes)
						state <= MS_LINE;
				end
				MS_LINE: begin
					if (k_yes) begin
						state <= MS_FRAME;
						shown <= {1'b0, opts[O_ESF]};
					end else if (k_no) begin
						state <= MS_DTE;
					end else begin
						state <= MS_CFG;
					end
				end
				MS_DTE: begin
					if (k_home)
						state <= MS_CFG;
				end
				MS_TIMING: begin
					if (k_home) begin
						state <= MS_LINE;
					end else if (k_yes) begin
						shown <= (shown == TIME_LAST) ? 2'h0 : shown + 2'h1;
					end else begin
						opts[O_TIM+:2] <= shown;
						shown <= {1'b0, opts[O_LLB]};
						state <= MS_LLB;
					end
				end
				MS_FRAME, MS_CODE, MS_STUFF, MS_PRM, MS_HIST, MS_LLB,
				MS_PLB, MS_IDLE, MS_YEL: begin
					if (k_home) begin
						state <= MS_LINE;
					end else if (k_yes) begin
						shown[0] <= ~shown[0];
					end else begin
						// Save the shown value, then load the next one; after the last one (alarm), go back to the line prompt.
						case (state)
							MS_FRAME: begin
								opts[O_ESF] <= shown[0];
								shown <= {1'b0, opts[O_B8ZS]};
								state <= MS_CODE;
							end
							MS_CODE: begin
								opts[O_B8ZS] <= shown[0];
								shown <= {1'b0, opts[O_STUFF]};
								state <= MS_STUFF;
							end
							MS_STUFF: begin
								opts[O_STUFF] <= shown[0];
								shown <= {1'b0, opts[O_PRM]};
								state <= MS_PRM;
							end
							MS_PRM: begin
								opts[O_PRM] <= shown[0];
								shown <= {1'b0, opts[O_HIST]};
								state <= MS_HIST;
							end
							MS_HIST: begin
								opts[O_HIST] <= shown[0];
								shown <= opts[O_TIM+:2];
								state <= MS_TIMING;
							end
							MS_LLB: begin
								opts[O_LLB] <= shown[0];
								shown <= {1'b0, opts[O_PLB]};
								state <= MS_PLB;
							end
							MS_PLB: begin
								opts[O_PLB] <= shown[0];
								shown <= {1'b0, opts[O_IDLE]};
								state <= MS_IDLE;
							end
							MS_IDLE: begin
								opts[O_IDLE] <= shown[0];
								shown <= {1'b0, opts[O_YEL]};
								state <= MS_YEL;
							end
							default: begin
								opts[O_YEL] <= shown[0];
								state <= MS_LINE;
							end
						endcase
					end
				end
				MS_PERF: begin
					if (k_yes)
						state <= MS_TPROMPT;
				end
				MS_TPROMPT: begin
					if (k_yes) begin
						state <= MS_TVIEW;
						cat <= 3'h0;
					end else if (k_no) begin
						topt <= (topt == TOPT_LAST) ? 2'h0 : topt + 2'h1;
					end else begin
						state <= MS_PERF;
					end
				end
				MS_TVIEW: begin
					if (k_no)
						cat <= (cat == CAT_LAST) ? 3'h0 : cat + 3'h1;
					else if (k_home)
						state <= MS_PERF;
				end
				default: state <= MS_CFG;
			endcase
		end
	end

	// Viewed interval: software picks one in range, YES steps to the next.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			intv <= INTV_FIRST;
		end else if (wr && paddr_i == OFF_INTV) begin
			if (pwdata_i[6:0] >= INTV_FIRST && pwdata_i[6:0] <= INTV_LAST)
				intv <= pwdata_i[6:0];
		end else if (k_yes && state == MS_TVIEW) begin
			intv <= (intv == INTV_LAST) ? INTV_FIRST : intv + 7'h1;
		end
	end

	// Two-flop synchronisers on the line pins, third stage for edges.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			llb_s <= 3'h0;
			plb_s <= 3'h0;
			hreq_s <= 3'h0;
		end else if (ce_i) begin
			llb_s <= {llb_s[1:0], line_loopback_enable_code_i};
			plb_s <= {plb_s[1:0], payload_loopback_enable_code_i};
			hreq_s <= {hreq_s[1:0], hist_req_i};
		end
	end

	// Second and interval timing; history depth saturates at one day.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sec_cnt <= 32'h0;
			intv_sec <= 10'h0;
			sec_tick <= 1'b0;
			hist_count_o <= 7'h0;
		end else if (ce_i) begin
			sec_tick <= sec_cnt == 32'(SEC_CYCLES - 1);
			sec_cnt <= (sec_cnt == 32'(SEC_CYCLES - 1)) ? 32'h0 :
				sec_cnt + 32'h1;
			if (sec_tick) begin
				if (intv_sec == 10'(SEC_PER_INTV - 1)) begin
					intv_sec <= 10'h0;
					if (hist_count_o != INTV_LAST)
						hist_count_o <= hist_count_o + 7'h1;
				end else begin
					intv_sec <= intv_sec + 10'h1;
				end
			end
		end
	end

	// Per-second error flags and the report and history pulses.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prm_data_o <= 4'h0;
			prm_send_o <= 1'b0;
			hist_send_o <= 1'b0;
		end else if (ce_i) begin
			if (sec_tick)
				prm_data_o <= {prm_data_o[PRM_SECS-2:0], err_event_i};
			prm_send_o <= sec_tick & opts[O_ESF] & opts[O_PRM];
			hist_send_o <= hreq_s[1] & ~hreq_s[2] & opts[O_ESF] &
				opts[O_HIST];
		end
	end

	// Loopbacks, idle pattern, alarm and timing follow the saved options.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_loop_o <= 1'b0;
			payload_loop_o <= 1'b0;
			reframe_o <= 1'b0;
			idle_byte_o <= IDLE_ONES;
			yellow_tx_o <= 1'b0;
			timing_sel_o <= 2'h0;
			dte_clk_drive_o <= 1'b1;
		end else if (ce_i) begin
			line_loop_o <= opts[O_LLB] & llb_s[1];
			payload_loop_o <= opts[O_PLB] & plb_s[1];
			reframe_o <= opts[O_PLB] & plb_s[1];
			idle_byte_o <= opts[O_IDLE] ? IDLE_7F : IDLE_ONES;
			yellow_tx_o <= opts[O_YEL] & yellow_req_i;
			timing_sel_o <= opts[O_TIM+:2];
			dte_clk_drive_o <= opts[O_TIM+:2] != TIME_DTE;
		end
	end

	// Oldest symbol, with a mark forced after fifteen zeros under AMI.
	always_comb begin
		out_sym = sym[15:14];
		if (!opts[O_B8ZS] && opts[O_STUFF] && zrun == STUFF_ZEROS &&
			out_sym == SYM_Z)
			out_sym = SYM_M;
	end

	// Eight-symbol delay line; an all-zero run is replaced by 000VB0VB.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sym <= 16'h0;
			last_pos <= 1'b0;
			zrun <= 4'h0;
			tx_pos_o <= 1'b0;
			tx_neg_o <= 1'b0;
		end else if (ce_i && tx_stb_i) begin
			if (opts[O_B8ZS] && {sym[13:0], 1'b0, tx_bit_i} == 16'h0)
				sym <= SUB_PAT;
			else
				sym <= {sym[13:0], 1'b0, tx_bit_i};
			zrun <= (out_sym == SYM_Z) ? zrun + 4'h1 : 4'h0;
			tx_pos_o <= (out_sym == SYM_M) ? ~last_pos :
				(out_sym == SYM_V) ? last_pos : 1'b0;
			tx_neg_o <= (out_sym == SYM_M) ? last_pos :
				(out_sym == SYM_V) ? ~last_pos : 1'b0;
			if (out_sym == SYM_M)
				last_pos <= ~last_pos;
		end
	end

	// Checks on the option logic.
	a_intv_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		intv >= INTV_FIRST && intv <= INTV_LAST)
		else $error("interval index out of range");
	a_yes_keeps_cat: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) k_yes && state == MS_TVIEW |=> $stable(cat))
		else $error("YES changed category");
	a_no_steps_cat: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) k_no && state == MS_TVIEW && cat != CAT_LAST
		|=> cat == $past(cat) + 3'h1)
		else $error("NO did not step category");
	a_line_no_dte: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) k_no && state == MS_LINE && ~pwdata_i[KEY_PERF]
		&& ~pwdata_i[KEY_CFG] |=> state == MS_DTE)
		else $error("NO at line prompt did not go to DTE");
	a_toggle_no_save: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) k_yes && state == MS_FRAME |=> $stable(opts))
		else $error("toggle changed saved option");
	a_b8zs_no_run: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) opts[O_B8ZS] && ce_i && tx_stb_i
		|=> sym != 16'h0)
		else $error("eight zeros left in line");
	a_stuff_ami_only: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) opts[O_B8ZS] |-> out_sym == sym[15:14])
		else $error("stuffing under B8ZS");
	a_prm_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		prm_send_o |-> $past(opts[O_ESF] & opts[O_PRM] & sec_tick))
		else $error("report sent without ESF and option");
	a_hist_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		hist_send_o |-> $past(opts[O_ESF] & opts[O_HIST]))
		else $error("history sent while disabled");
	a_loop_enable: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) ce_i && !opts[O_LLB] |=> !line_loop_o)
		else $error("loop taken while disabled");
	a_yellow_gate: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) yellow_tx_o |-> $past(opts[O_YEL]))
		else $error("yellow sent while disabled");
	c_frame_save: cover property (@(posedge clk_sys_i)
		k_no && state == MS_FRAME);
	c_b8zs_sub: cover property (@(posedge clk_sys_i) sym == SUB_PAT);
	c_view_wrap: cover property (@(posedge clk_sys_i)
		k_yes && state == MS_TVIEW && intv == INTV_LAST);
	c_hist_send: cover property (@(posedge clk_sys_i) hist_send_o);
endmodule
